// ==== lkm_pkg.sv ====
package lkm_pkg;
	// ----------------------------------------------------------------
	// sizes and encodings
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int NUM_LANES = 4;
	localparam int TMR_W = 16;
	// polarity check window within a training ordered set
	localparam logic [4:0] POL_SYM_FIRST = 5'h06;
	localparam logic [4:0] POL_SYM_LAST = 5'h10;
	// link width encodings as carried in width fields
	localparam logic [5:0] WIDTH_X1 = 6'h01;
	localparam logic [5:0] WIDTH_X2 = 6'h02;
	localparam logic [5:0] WIDTH_X4 = 6'h04;
	// reset values
	localparam logic [5:0] MAX_WIDTH_RST = 6'h04;
	localparam logic [7:0] PWR_SCALE_RST = 8'h00;
	localparam logic [1:0] PWR_VALUE_RST = 2'h0;
	localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
	// port 0 is the upstream port
	localparam int UP_PORT = 0;

	// link power state per port
	typedef enum logic [2:0] {
		LKM_DOWN  = 3'b000,
		LKM_L0    = 3'b001,
		LKM_L0S   = 3'b010,
		LKM_L1REQ = 3'b011,
		LKM_L1    = 3'b100,
		LKM_L23   = 3'b101
	} lkm_state_t;

	// per-port status from the training logic
	typedef struct packed {
		logic       link_up;
		logic       disabled;
		logic       trained;
		logic [5:0] trained_width;
		logic       in_d3;
		logic       d3hot;
		logic       rx_in_l0s;
		logic       tlp_sendable;
		logic       dllp_pending;
		logic       pm_turnoff_ack;
		logic       slot_cap_write;
	} lkm_port_in_t;

	// reversal lane map for a given maximum width
	function automatic logic [1:0] lkm_rev_lane(input logic [1:0] lane,
			input logic [5:0] maxw);
		logic [1:0] r;
		r = lane;
		if (maxw == WIDTH_X4) begin
			r = 2'h3 - lane;
		end else if (maxw == WIDTH_X2) begin
			r = {lane[1], ~lane[0]};
		end
		return r;
	endfunction : lkm_rev_lane
endpackage : lkm_pkg

// ==== lkm_link_mgr.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01: invert rx data on inverted training symbols
// R02: polarity kept separately for every lane
// R03: negotiate x4/x2/x1 and report width
// R04: max width writable when unlocked, applied later
// R05: idle lanes to L1, disabled lanes off
// R06: reverse lanes by configured maximum width
// R07: upstream retrain only while unlocked
// R08: downstream retrain regardless of unlock
// R09: discard queued TLPs on link down
// R10: TLPs to a down port are unsupported
// R11: bridge config access works while down
// R12: advertise ingress queue credits on link up
// R13: capture slot power scale and value
// R14: send power limit on write or link up
// R15: L2/L3 ready after turn-off ack, quiet
// R16: D3hot moves the link to L1
// R17: ASPM transitions run by hardware
// R18: L0s after entry timer expires
// R19: upstream L0s entry conditions
// R20: downstream L0s entry conditions
// R21: upstream requests L1, nak leads to L0s
// R22: upstream L1 only if downstreams in L1
// R23: entry counters restart on broken condition
// R24: standard reversal order within maximum width
module lkm_link_mgr
	import lkm_pkg::*;
#(
	parameter int NP = NUM_PORTS,
	parameter int NL = NUM_LANES
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire lkm_port_in_t [NP-1:0] port_i,
	input  wire logic [NP-1:0][NL-1:0] ts_sym_inverted_i,
	input  wire logic [4:0]           ts_sym_index_i,
	input  wire logic [NP-1:0]        ts_sym_valid_i,
	input  wire logic [NP-1:0]        training_start_i,
	input  wire logic                 register_unlock_bit_i,
	input  wire logic [NP-1:0]        max_width_wr_i,
	input  wire logic [5:0]           max_width_wdata_i,
	input  wire logic [NP-1:0]        retrain_link_bit_wr_i,
	input  wire logic [NP-1:0]        aspm_l0s_en_i,
	input  wire logic [NP-1:0]        aspm_l1_en_i,
	input  wire logic [TMR_W-1:0]     l0s_entry_timer_i,
	input  wire logic [TMR_W-1:0]     l1_entry_timer_i,
	input  wire logic                 spl_msg_rx_i,
	input  wire logic [15:0]          spl_payload_i,
	input  wire logic                 l1_ack_i,
	input  wire logic                 l1_nak_i,
	input  wire logic [11:0]          ingress_buffer_queue_size_i,
	output logic [NP-1:0][NL-1:0]     rx_invert_o,
	output logic [NP-1:0][5:0]        negotiated_width_field_o,
	output logic [NP-1:0][5:0]        max_width_field_o,
	output logic [NP-1:0][NL-1:0]     lane_l1_o,
	output logic [NP-1:0][NL-1:0]     lane_off_o,
	output logic [NP-1:0][NL-1:0][1:0] lane_map_o,
	output logic [NP-1:0]             goto_recovery_o,
	output logic [NP-1:0]             discard_queued_o,
	output logic [NP-1:0]             route_as_ur_o,
	output logic [NP-1:0]             cfg_access_ok_o,
	output logic [NP-1:0]             credit_adv_o,
	output logic [11:0]               credit_value_o,
	output logic [7:0]                captured_power_scale_o,
	output logic [1:0]                captured_power_value_o,
	output logic [NP-1:0]             spl_send_o,
	output logic [NP-1:0]             link_quiet_o,
	output logic                      l1_request_o,
	output lkm_state_t [NP-1:0]       link_state_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	lkm_state_t [NP-1:0]  st;
	lkm_state_t [NP-1:0]  next_st;
	logic [NP-1:0][TMR_W-1:0] l0s_cnt;
	logic [TMR_W-1:0]     l1_cnt;
	logic [NP-1:0]        up_d;
	logic [NP-1:0][5:0]   max_pend;
	logic [NP-1:0]        l0s_cond;
	logic [NP-1:0]        l0s_done;
	logic [NP-1:0]        ds_ok_l0s;
	logic [NP-1:0]        ds_ok_l1;
	logic                 l1_cond;
	logic                 l1_done;
	logic [NP-1:0]        pol_win;
	logic [NP-1:0][5:0]   next_nw;

	// ----------------------------------------------------------------
	// entry conditions
	// ----------------------------------------------------------------
	// downstream ports that matter: not in D3 and link up
	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_cond
			assign pol_win[g] = ts_sym_valid_i[g] &&
				ts_sym_index_i >= POL_SYM_FIRST &&
				ts_sym_index_i <= POL_SYM_LAST;
			// R03: width taken from training
			assign next_nw[g] = port_i[g].trained ?
				port_i[g].trained_width :
				(port_i[g].link_up ? negotiated_width_field_o[g] : 6'h00);
			if (g == UP_PORT) begin : g_up
				assign ds_ok_l0s[g] = 1'b1;
				assign ds_ok_l1[g] = 1'b1;
				// R19: upstream L0s conditions
				assign l0s_cond[g] = (&ds_ok_l0s) &&
					!port_i[g].tlp_sendable &&
					!port_i[g].dllp_pending;
			end else begin : g_dn
				assign ds_ok_l0s[g] = port_i[g].in_d3 ||
					!port_i[g].link_up || port_i[g].rx_in_l0s;
				// R22: downstream already in L1
				assign ds_ok_l1[g] = port_i[g].in_d3 ||
					!port_i[g].link_up || st[g] == LKM_L1;
				// R20: downstream L0s conditions
				assign l0s_cond[g] = port_i[UP_PORT].rx_in_l0s &&
					!port_i[g].tlp_sendable &&
					!port_i[g].dllp_pending;
			end
			assign l0s_done[g] = l0s_cond[g] &&
				l0s_cnt[g] >= l0s_entry_timer_i;
		end
	endgenerate
	assign l1_cond = (&ds_ok_l1) && !port_i[UP_PORT].tlp_sendable &&
		!port_i[UP_PORT].dllp_pending;
	assign l1_done = l1_cond && l1_cnt >= l1_entry_timer_i;

	// ----------------------------------------------------------------
	// link power state machine
	// ----------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			next_st[p] = st[p];
			case (st[p])
				LKM_DOWN: begin
					if (port_i[p].link_up) begin
						next_st[p] = LKM_L0;
					end
				end
				LKM_L0, LKM_L0S: begin
					// R15: turn-off ack to L2/L3 ready
					if (port_i[p].pm_turnoff_ack) begin
						next_st[p] = LKM_L23;
					// R16: D3hot forces L1
					end else if (port_i[p].d3hot) begin
						next_st[p] = LKM_L1;
					// R21: only upstream asks for L1
					end else if (p == UP_PORT && aspm_l1_en_i[p] &&
							l1_done) begin
						next_st[p] = LKM_L1REQ;
					// R17: hardware moves to L0s
					end else if (st[p] == LKM_L0 && aspm_l0s_en_i[p] &&
							l0s_done[p]) begin
						next_st[p] = LKM_L0S;
					end else if (st[p] == LKM_L0S && !l0s_cond[p]) begin
						next_st[p] = LKM_L0;
					end
				end
				LKM_L1REQ: begin
					// R21: ack to L1, refusal to L0s
					if (l1_ack_i) begin
						next_st[p] = LKM_L1;
					end else if (l1_nak_i) begin
						next_st[p] = LKM_L0S;
					end
				end
				LKM_L1: begin
					// R15: turn-off ack also from L1
					if (port_i[p].pm_turnoff_ack) begin
						next_st[p] = LKM_L23;
					end else if (!port_i[p].d3hot && !l1_cond &&
							p == UP_PORT) begin
						next_st[p] = LKM_L0;
					end else if (p != UP_PORT && !port_i[p].d3hot &&
							port_i[p].tlp_sendable) begin
						next_st[p] = LKM_L0;
					end
				end
				LKM_L23: next_st[p] = LKM_L23;
				default: next_st[p] = LKM_DOWN;
			endcase
			if (!port_i[p].link_up) begin
				next_st[p] = LKM_DOWN;
			end
		end
	end

	// ----------------------------------------------------------------
	// timers and power state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '{default: LKM_DOWN};
			l0s_cnt <= '0;
			l1_cnt <= TMR_RST;
			up_d <= '0;
		end else begin
			st <= next_st;
			for (int p = 0; p < NP; p++) begin
				up_d[p] <= port_i[p].link_up;
				// R23: restart on broken condition
				if (!l0s_cond[p] || st[p] != LKM_L0) begin
					l0s_cnt[p] <= TMR_RST;
				// R18: count to the entry time
				end else if (l0s_cnt[p] != '1) begin
					l0s_cnt[p] <= l0s_cnt[p] + 1'b1;
				end
			end
			// R23: L1 counter restarts too
			if (!l1_cond || (st[UP_PORT] != LKM_L0 &&
					st[UP_PORT] != LKM_L0S)) begin
				l1_cnt <= TMR_RST;
			end else if (l1_cnt != '1) begin
				l1_cnt <= l1_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// lane, width and link event outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_invert_o <= '0;
			negotiated_width_field_o <= '0;
			max_width_field_o <= '{default: MAX_WIDTH_RST};
			max_pend <= '{default: MAX_WIDTH_RST};
			lane_l1_o <= '0;
			lane_off_o <= '0;
			lane_map_o <= '0;
			goto_recovery_o <= '0;
			discard_queued_o <= '0;
			route_as_ur_o <= '0;
			cfg_access_ok_o <= '0;
			credit_adv_o <= '0;
			credit_value_o <= '0;
			captured_power_scale_o <= PWR_SCALE_RST;
			captured_power_value_o <= PWR_VALUE_RST;
			spl_send_o <= '0;
			link_quiet_o <= '0;
			l1_request_o <= 1'b0;
			link_state_o <= '{default: LKM_DOWN};
		end else begin
			link_state_o <= next_st;
			// R21: request held while waiting
			l1_request_o <= next_st[UP_PORT] == LKM_L1REQ;
			credit_value_o <= ingress_buffer_queue_size_i;
			if (spl_msg_rx_i) begin
				// R13: capture power limit fields
				captured_power_scale_o <= spl_payload_i[7:0];
				captured_power_value_o <= spl_payload_i[9:8];
			end
			for (int p = 0; p < NP; p++) begin
				// R01: per-lane inversion in symbols 6..16
				if (training_start_i[p]) begin
					rx_invert_o[p] <= '0;
				end else if (pol_win[p]) begin
					// R02: each lane set on its own
					rx_invert_o[p] <= rx_invert_o[p] |
						ts_sym_inverted_i[p];
				end
				// R04: writable only while unlocked
				if (max_width_wr_i[p] && register_unlock_bit_i) begin
					max_pend[p] <= max_width_wdata_i;
				end
				// R04: applied at next training
				if (training_start_i[p]) begin
					max_width_field_o[p] <= max_pend[p];
				end
				// R03: report negotiated width
				negotiated_width_field_o[p] <= next_nw[p];
				for (int l = 0; l < NL; l++) begin
					// R05: unused lanes low power
					lane_l1_o[p][l] <= port_i[p].link_up &&
						(l >= int'(next_nw[p]));
					// R05: disabled port powers lanes down
					lane_off_o[p][l] <= port_i[p].disabled;
					// R06: R24: reversal by maximum width
					lane_map_o[p][l] <= lkm_rev_lane(2'(l),
						max_width_field_o[p]);
				end
				// R07: R08: retrain to recovery
				goto_recovery_o[p] <= retrain_link_bit_wr_i[p] &&
					(p != UP_PORT || register_unlock_bit_i);
				// R09: discard on link going down
				discard_queued_o[p] <= up_d[p] && !port_i[p].link_up;
				// R10: route to down port as UR
				route_as_ur_o[p] <= !port_i[p].link_up;
				// R11: bridge config always serviced
				cfg_access_ok_o[p] <= 1'b1;
				// R12: credits on link up
				credit_adv_o[p] <= !up_d[p] && port_i[p].link_up;
				// R14: power limit on write or link up
				spl_send_o[p] <= (p != UP_PORT) &&
					((port_i[p].slot_cap_write && port_i[p].link_up) ||
					(!up_d[p] && port_i[p].link_up));
				// R15: no traffic in L2/L3 ready
				link_quiet_o[p] <= next_st[p] == LKM_L23;
			end
		end
	end
endmodule : lkm_link_mgr
`default_nettype wire

// ==== lkm_link_mgr_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module lkm_link_mgr_chk
	import lkm_pkg::*;
#(
	parameter int NP = NUM_PORTS,
	parameter int NL = NUM_LANES
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire lkm_port_in_t [NP-1:0] port_i,
	input wire logic                  register_unlock_bit_i,
	input wire logic [NP-1:0]         max_width_wr_i,
	input wire logic [NP-1:0]         training_start_i,
	input wire logic [NP-1:0]         retrain_link_bit_wr_i,
	input wire logic                  spl_msg_rx_i,
	input wire logic [15:0]           spl_payload_i,
	input wire logic                  l1_nak_i,
	input wire logic [11:0]           ingress_buffer_queue_size_i,
	input wire logic [NP-1:0][5:0]    max_width_field_o,
	input wire logic [NP-1:0][NL-1:0] lane_off_o,
	input wire logic [NP-1:0]         goto_recovery_o,
	input wire logic [NP-1:0]         discard_queued_o,
	input wire logic [NP-1:0]         route_as_ur_o,
	input wire logic [NP-1:0]         credit_adv_o,
	input wire logic [11:0]           credit_value_o,
	input wire logic [7:0]            captured_power_scale_o,
	input wire logic [1:0]            captured_power_value_o,
	input wire logic [NP-1:0]         spl_send_o,
	input wire lkm_state_t [NP-1:0]   link_state_o
);
	// ----------------------------------------------------------------
	// port relations
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// link edges on port 1
	sequence s_up;
		!port_i[1].link_up ##1 port_i[1].link_up;
	endsequence
	sequence s_dn;
		port_i[1].link_up ##1 !port_i[1].link_up;
	endsequence
	property p_up;
		s_up |=> credit_adv_o[1] && spl_send_o[1]
			&& credit_value_o == $past(ingress_buffer_queue_size_i);
	endproperty
	a_up: assert property (p_up) else $error("link up actions missing");
	property p_dn;
		s_dn |=> discard_queued_o[1] && route_as_ur_o[1];
	endproperty
	a_dn: assert property (p_dn) else $error("link down actions missing");
	property p_rtr_up;
		retrain_link_bit_wr_i[0] |=> goto_recovery_o[0] == $past(register_unlock_bit_i);
	endproperty
	a_rtr_up: assert property (p_rtr_up) else $error("upstream retrain wrong");
	property p_rtr_dn;
		retrain_link_bit_wr_i[1] |=> goto_recovery_o[1];
	endproperty
	a_rtr_dn: assert property (p_rtr_dn) else $error("downstream retrain lost");
	property p_spl;
		spl_msg_rx_i |=> captured_power_scale_o == $past(spl_payload_i[7:0])
			&& captured_power_value_o == $past(spl_payload_i[9:8]);
	endproperty
	a_spl: assert property (p_spl) else $error("power limit capture wrong");
	property p_wmax;
		max_width_wr_i[2] && !register_unlock_bit_i && !training_start_i[2]
			|=> $stable(max_width_field_o[2]);
	endproperty
	a_wmax: assert property (p_wmax) else $error("locked width write took");
	property p_off;
		port_i[2].disabled |=> lane_off_o[2] == 4'hf;
	endproperty
	a_off: assert property (p_off) else $error("disabled lanes still on");
	property p_nak;
		link_state_o[0] == LKM_L1REQ && l1_nak_i |=> link_state_o[0] == LKM_L0S;
	endproperty
	a_nak: assert property (p_nak) else $error("refused request not to L0s");
endmodule : lkm_link_mgr_chk
bind lkm_link_mgr lkm_link_mgr_chk #(.NP(NP), .NL(NL)) lkm_link_mgr_chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .port_i(port_i),
	.register_unlock_bit_i(register_unlock_bit_i), .max_width_wr_i(max_width_wr_i),
	.retrain_link_bit_wr_i(retrain_link_bit_wr_i), .spl_msg_rx_i(spl_msg_rx_i),
	.training_start_i(training_start_i),
	.spl_payload_i(spl_payload_i), .l1_nak_i(l1_nak_i),
	.ingress_buffer_queue_size_i(ingress_buffer_queue_size_i),
	.max_width_field_o(max_width_field_o), .lane_off_o(lane_off_o),
	.goto_recovery_o(goto_recovery_o), .discard_queued_o(discard_queued_o),
	.route_as_ur_o(route_as_ur_o), .credit_adv_o(credit_adv_o),
	.credit_value_o(credit_value_o), .captured_power_scale_o(captured_power_scale_o),
	.captured_power_value_o(captured_power_value_o), .spl_send_o(spl_send_o),
	.link_state_o(link_state_o));
`default_nettype wire

// ==== lkm_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module lkm_partner (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       l1_request_i,
	input  wire logic       nak_mode_i,
	input  wire logic [3:0] delay_i,
	output logic            l1_ack_o,
	output logic            l1_nak_o
);
	logic [3:0] wait_cnt;
	logic       answered;
	// one answer per request, after a delay
	// partner answer
	always_ff @(posedge clk_i) begin
		l1_ack_o <= 1'b0;
		l1_nak_o <= 1'b0;
		if (rst_i || !l1_request_i) begin
			answered <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (!answered && wait_cnt == delay_i) begin
			answered <= 1'b1;
			l1_ack_o <= !nak_mode_i;
			l1_nak_o <= nak_mode_i;
		end else if (!answered) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : lkm_partner
`default_nettype wire

// ==== lkm_link_mgr_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module lkm_link_mgr_tb;
	import lkm_pkg::*;
	localparam int NP = NUM_PORTS;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	lkm_port_in_t [NP-1:0] pin = '0;
	logic [NP-1:0][3:0] tinv = '0;
	logic [4:0] tidx = 5'h00;
	logic [NP-1:0] tsv = '0, tst = '0, mwr = '0, rtr = '0, l0en = '0, l1en = '0;
	logic unlock = 1'b0, splrx = 1'b0, nakm = 1'b0, ack, nak, l1req;
	logic [5:0] mwd = 6'h00;
	logic [15:0] tm0 = 16'h0006, tm1 = 16'h0004, spld = 16'h0000;
	logic [11:0] iqs = 12'h01a0, cval;
	logic [3:0] pdly = 4'h1;
	logic [NP-1:0][3:0] inv, ll1, off;
	logic [NP-1:0][5:0] nw, mw;
	logic [NP-1:0][3:0][1:0] map;
	logic [NP-1:0] rec, dis, ur, cfg, cadv, spls, quiet;
	logic [7:0] psc;
	logic [1:0] pval;
	lkm_state_t [NP-1:0] st;
	int fails = 0;
	int checks = 0;
	// ----------------------------------------------------------------
	// block, partner and clock
	// ----------------------------------------------------------------
	lkm_link_mgr lkm_link_mgr_i (.clk_i(clk_i), .rst_i(rst_i), .port_i(pin),
		.ts_sym_inverted_i(tinv), .ts_sym_index_i(tidx), .ts_sym_valid_i(tsv),
		.training_start_i(tst), .register_unlock_bit_i(unlock),
		.max_width_wr_i(mwr), .max_width_wdata_i(mwd), .retrain_link_bit_wr_i(rtr),
		.aspm_l0s_en_i(l0en), .aspm_l1_en_i(l1en), .l0s_entry_timer_i(tm0),
		.l1_entry_timer_i(tm1), .spl_msg_rx_i(splrx), .spl_payload_i(spld),
		.l1_ack_i(ack), .l1_nak_i(nak), .ingress_buffer_queue_size_i(iqs),
		.rx_invert_o(inv), .negotiated_width_field_o(nw), .max_width_field_o(mw),
		.lane_l1_o(ll1), .lane_off_o(off), .lane_map_o(map), .goto_recovery_o(rec),
		.discard_queued_o(dis), .route_as_ur_o(ur), .cfg_access_ok_o(cfg),
		.credit_adv_o(cadv), .credit_value_o(cval), .captured_power_scale_o(psc),
		.captured_power_value_o(pval), .spl_send_o(spls), .link_quiet_o(quiet),
		.l1_request_o(l1req), .link_state_o(st));
	lkm_partner lkm_partner_i (.clk_i(clk_i), .rst_i(rst_i), .l1_request_i(l1req),
		.nak_mode_i(nakm), .delay_i(pdly), .l1_ack_o(ack), .l1_nak_o(nak));
	always #5 clk_i = ~clk_i;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic wst(input int p, input lkm_state_t s, input int n);
		for (int i = 0; i < n && st[p] !== s; i++) tick(1);
		chk(st[p], s);
	endtask : wst
	task automatic summarize();
		if (fails == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_pol();
		logic [4:0] ix [4] = '{5'h05, 5'h06, 5'h10, 5'h11};
		logic [3:0] mk [4] = '{4'h8, 4'h1, 4'h4, 4'h2};
		@(posedge clk_i);
		tst[1] <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			tst[1] <= 1'b0;
			tsv[1] <= 1'b1;
			tidx <= ix[i];
			tinv[1] <= mk[i];
		end
		@(posedge clk_i);
		tsv[1] <= 1'b0;
		tick(2);
		chk(inv[1], 16'h0005);
	endtask : t_pol
	task automatic t_width();
		logic [5:0] w [3] = '{WIDTH_X4, WIDTH_X2, WIDTH_X1};
		logic [3:0] l [3] = '{4'h0, 4'hc, 4'he};
		@(posedge clk_i);
		tst[2] <= 1'b1;
		@(posedge clk_i);
		tst[2] <= 1'b0;
		tick(1);
		chk(map[2], 16'h001b);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			pin[2].link_up <= 1'b1;
			pin[2].trained <= 1'b1;
			pin[2].trained_width <= w[i];
			tick(1);
			chk(nw[2], w[i]);
			chk(ll1[2], l[i]);
		end
		for (int u = 0; u < 2; u++) begin
			@(posedge clk_i);
			unlock <= u[0];
			mwd <= WIDTH_X2;
			mwr[2] <= 1'b1;
			@(posedge clk_i);
			mwr[2] <= 1'b0;
			tick(1);
			chk(mw[2], WIDTH_X4);
		end
		chk(map[2], 16'h001b);
		@(posedge clk_i);
		tst[2] <= 1'b1;
		@(posedge clk_i);
		tst[2] <= 1'b0;
		pin[2].disabled <= 1'b1;
		tick(1);
		chk(map[2], 16'h00b1);
		chk(mw[2], WIDTH_X2);
		chk(off[2], 16'h000f);
	endtask : t_width
	task automatic t_rtr();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			unlock <= i[1];
			rtr[i%2] <= 1'b1;
			@(posedge clk_i);
			rtr <= '0;
			#1;
			chk(rec[i%2], i != 0);
		end
	endtask : t_rtr
	task automatic t_link();
		@(posedge clk_i);
		pin[1].link_up <= 1'b1;
		tick(1);
		chk({cadv[1], spls[1], 2'b00, cval}, 16'hc1a0);
		@(posedge clk_i);
		pin[1].slot_cap_write <= 1'b1;
		@(posedge clk_i);
		pin[1].slot_cap_write <= 1'b0;
		pin[1].link_up <= 1'b0;
		#1;
		chk(spls[1], 1'b1);
		tick(1);
		chk({dis[1], ur[1], cfg[1]}, 16'h0007);
	endtask : t_link
	task automatic t_spl();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			splrx <= 1'b1;
			spld <= i ? 16'hfd3c : 16'h02a5;
			@(posedge clk_i);
			splrx <= 1'b0;
			tick(1);
			chk({psc, 6'h00, pval}, i ? 16'h3c01 : 16'ha502);
		end
	endtask : t_spl
	task automatic t_l0s();
		@(posedge clk_i);
		pin[0].rx_in_l0s <= 1'b1;
		pin[3].link_up <= 1'b1;
		tick(12);
		chk(st[3], LKM_L0);
		@(posedge clk_i);
		l0en[3] <= 1'b1;
		tick(3);
		@(posedge clk_i);
		pin[3].tlp_sendable <= 1'b1;
		@(posedge clk_i);
		pin[3].tlp_sendable <= 1'b0;
		tick(5);
		chk(st[3], LKM_L0);
		wst(3, LKM_L0S, 6);
	endtask : t_l0s
	task automatic t_l1();
		@(posedge clk_i);
		tm0 <= 16'h0040;
		pin[0].link_up <= 1'b1;
		pin[2].link_up <= 1'b0;
		pin[3].rx_in_l0s <= 1'b1;
		l1en[0] <= 1'b1;
		tick(15);
		chk(l1req, 1'b0);
		@(posedge clk_i);
		pin[3].in_d3 <= 1'b1;
		wst(0, LKM_L1, 30);
		@(posedge clk_i);
		pin[0].tlp_sendable <= 1'b1;
		nakm <= 1'b1;
		pdly <= 4'h5;
		tick(3);
		@(posedge clk_i);
		pin[0].tlp_sendable <= 1'b0;
		wst(0, LKM_L0S, 40);
	endtask : t_l1
	task automatic t_pm();
		@(posedge clk_i);
		pin[4].link_up <= 1'b1;
		pin[4].d3hot <= 1'b1;
		wst(4, LKM_L1, 10);
		@(posedge clk_i);
		pin[4].pm_turnoff_ack <= 1'b1;
		wst(4, LKM_L23, 10);
		chk(quiet[4], 1'b1);
	endtask : t_pm
	// main sequence after a six cycle reset
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		chk(mw[1], WIDTH_X4);
		chk(st[1], LKM_DOWN);
		t_pol();
		t_width();
		t_rtr();
		t_link();
		t_spl();
		t_l0s();
		t_l1();
		t_pm();
		summarize();
	end
	// hang guard
	initial begin
		#100000;
		fails++;
		summarize();
	end
endmodule : lkm_link_mgr_tb
`default_nettype wire
